// ===== design/pms_status.sv
// Per-channel limit and readback store with fault code and indicator reporting
`timescale 1ns/1ns
`default_nettype none

module pms_status #(
	parameter int unsigned BLINK_HALF = pms_pkg::BLINK_HALF_CYCLES
) (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire pms_pkg::pms_host_req_t host_req,
	output logic [pms_pkg::VALUE_W-1:0] rd_data,
	output logic rd_valid,
	input wire pms_pkg::pms_loop_upd_t loop_upd,
	input wire pms_pkg::pms_faults_t faults_async,
	output logic [pms_pkg::VALUE_W-1:0] lower_output_limit_bus,
	output logic [pms_pkg::VALUE_W-1:0] upper_output_limit_bus,
	output logic [pms_pkg::CH_W-1:0] limit_ch,
	output logic [pms_pkg::CODE_W-1:0] error_code,
	output logic alarm_active,
	output logic warning_active,
	output logic run_led,
	output logic err_led
);

	localparam int CNT_W = $clog2(BLINK_HALF + 1);

	// Lowest numbered channel with a flag set; callers gate on a nonzero vector
	function automatic logic [pms_pkg::CH_W-1:0] first_ch(
		input logic [pms_pkg::CHANNELS-1:0] flags
	);
		logic [pms_pkg::CH_W-1:0] idx;
		idx = '0;
		for (int i = pms_pkg::CHANNELS - 1; i >= 0; i--)
		begin
			if (flags[i])
			begin
				idx = pms_pkg::CH_W'(i);
			end
		end
		return idx;
	endfunction : first_ch

	function automatic logic [pms_pkg::CODE_W-1:0] ch_code(
		input logic [pms_pkg::CODE_W-1:0] base,
		input logic [pms_pkg::CHANNELS-1:0] flags
	);
		return base | pms_pkg::CODE_W'(first_ch(flags));
	endfunction : ch_code

	// Parameter store
	logic [pms_pkg::VALUE_W-1:0] lower_reg [pms_pkg::CHANNELS];
	logic [pms_pkg::VALUE_W-1:0] lower_next [pms_pkg::CHANNELS];
	logic [pms_pkg::VALUE_W-1:0] upper_reg [pms_pkg::CHANNELS];
	logic [pms_pkg::VALUE_W-1:0] upper_next [pms_pkg::CHANNELS];
	logic [pms_pkg::VALUE_W-1:0] out_reg [pms_pkg::CHANNELS];
	logic [pms_pkg::VALUE_W-1:0] out_next [pms_pkg::CHANNELS];
	logic [pms_pkg::VALUE_W-1:0] integ_reg [pms_pkg::CHANNELS];
	logic [pms_pkg::VALUE_W-1:0] integ_next [pms_pkg::CHANNELS];
	logic [pms_pkg::VALUE_W-1:0] rd_data_reg;
	logic [pms_pkg::VALUE_W-1:0] rd_data_next;
	logic rd_valid_reg;
	logic rd_valid_next;
	logic [pms_pkg::VALUE_W-1:0] lo_bus_reg;
	logic [pms_pkg::VALUE_W-1:0] lo_bus_next;
	logic [pms_pkg::VALUE_W-1:0] up_bus_reg;
	logic [pms_pkg::VALUE_W-1:0] up_bus_next;
	logic [pms_pkg::CH_W-1:0] lim_ch_reg;
	logic [pms_pkg::CH_W-1:0] lim_ch_next;

	always_comb
	begin
		for (int c = 0; c < pms_pkg::CHANNELS; c++)
		begin
			lower_next[c] = lower_reg[c];
			upper_next[c] = upper_reg[c];
			out_next[c] = out_reg[c];
			integ_next[c] = integ_reg[c];
		end
		if (host_req.wr_en)
		begin
			// Output and integral selections are monitor-only: writes fall through
			unique case (host_req.sel)
				pms_pkg::PMS_SEL_LOWER: lower_next[host_req.ch] = host_req.wdata;
				pms_pkg::PMS_SEL_UPPER: upper_next[host_req.ch] = host_req.wdata;
				pms_pkg::PMS_SEL_OUTPUT: ;
				pms_pkg::PMS_SEL_INTEGRAL: ;
			endcase
		end
		if (loop_upd.valid)
		begin
			out_next[loop_upd.ch] = loop_upd.output_value;
			integ_next[loop_upd.ch] = loop_upd.integral;
		end
		rd_valid_next = host_req.rd_en;
		rd_data_next = rd_data_reg;
		if (host_req.rd_en)
		begin
			unique case (host_req.sel)
				pms_pkg::PMS_SEL_LOWER: rd_data_next = lower_reg[host_req.ch];
				pms_pkg::PMS_SEL_UPPER: rd_data_next = upper_reg[host_req.ch];
				pms_pkg::PMS_SEL_OUTPUT: rd_data_next = out_reg[host_req.ch];
				pms_pkg::PMS_SEL_INTEGRAL: rd_data_next = integ_reg[host_req.ch];
			endcase
		end
		// Limits are shown to the control loop one channel per cycle, round robin
		lim_ch_next = lim_ch_reg + pms_pkg::CH_W'(1);
		lo_bus_next = lower_reg[lim_ch_reg];
		up_bus_next = upper_reg[lim_ch_reg];
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			for (int c = 0; c < pms_pkg::CHANNELS; c++)
			begin
				lower_reg[c] <= pms_pkg::VALUE_RESET;
				upper_reg[c] <= pms_pkg::VALUE_RESET;
				out_reg[c] <= pms_pkg::VALUE_RESET;
				integ_reg[c] <= pms_pkg::VALUE_RESET;
			end
			rd_data_reg <= pms_pkg::VALUE_RESET;
			rd_valid_reg <= 1'b0;
			lo_bus_reg <= pms_pkg::VALUE_RESET;
			up_bus_reg <= pms_pkg::VALUE_RESET;
			lim_ch_reg <= '0;
		end
		else
		begin
			for (int c = 0; c < pms_pkg::CHANNELS; c++)
			begin
				lower_reg[c] <= lower_next[c];
				upper_reg[c] <= upper_next[c];
				out_reg[c] <= out_next[c];
				integ_reg[c] <= integ_next[c];
			end
			rd_data_reg <= rd_data_next;
			rd_valid_reg <= rd_valid_next;
			lo_bus_reg <= lo_bus_next;
			up_bus_reg <= up_bus_next;
			lim_ch_reg <= lim_ch_next;
		end
	end

	// Fault inputs come from analog monitors outside this clock domain
	pms_pkg::pms_faults_t sync1_reg;
	pms_pkg::pms_faults_t sync2_reg;

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			sync1_reg <= '0;
			sync2_reg <= '0;
		end
		else
		begin
			sync1_reg <= faults_async;
			sync2_reg <= sync1_reg;
		end
	end

	// Fault priority and indicator selection
	logic [pms_pkg::CODE_W-1:0] code_reg;
	logic [pms_pkg::CODE_W-1:0] code_next;
	logic alarm_reg;
	logic alarm_next;
	logic warn_reg;
	logic warn_next;
	pms_pkg::pms_err_mode_t mode_reg;
	pms_pkg::pms_err_mode_t mode_next;
	logic run_reg;
	logic run_next;

	always_comb
	begin
		code_next = pms_pkg::CODE_NONE;
		mode_next = pms_pkg::PMS_ERR_OFF;
		alarm_next = 1'b1;
		warn_next = 1'b0;
		// Alarms first so a warning can never mask a stopped module
		if (sync2_reg.hw_fail)
		begin
			code_next = pms_pkg::CODE_HW_FAIL;
		end
		else if (sync2_reg.supply_fault)
		begin
			code_next = pms_pkg::CODE_SUPPLY;
		end
		else if (sync2_reg.cjc_fault)
		begin
			code_next = pms_pkg::CODE_CJC;
		end
		else if (sync2_reg.cal_fault)
		begin
			code_next = pms_pkg::CODE_CAL;
		end
		else if (|sync2_reg.range_alarm)
		begin
			code_next = ch_code(pms_pkg::CODE_RANGE_ALARM, sync2_reg.range_alarm);
		end
		else
		begin
			alarm_next = 1'b0;
			if (|sync2_reg.range_warn_blink)
			begin
				code_next = ch_code(pms_pkg::CODE_RANGE_BLINK, sync2_reg.range_warn_blink);
				mode_next = pms_pkg::PMS_ERR_BLINK;
				warn_next = 1'b1;
			end
			else if (|sync2_reg.range_warn_quiet)
			begin
				code_next = ch_code(pms_pkg::CODE_RANGE_QUIET, sync2_reg.range_warn_quiet);
				warn_next = 1'b1;
			end
		end
		if (alarm_next)
		begin
			mode_next = pms_pkg::PMS_ERR_ON;
		end
		run_next = !alarm_next;
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			code_reg <= pms_pkg::CODE_NONE;
			alarm_reg <= 1'b0;
			warn_reg <= 1'b0;
			mode_reg <= pms_pkg::PMS_ERR_OFF;
			run_reg <= 1'b1;
		end
		else
		begin
			code_reg <= code_next;
			alarm_reg <= alarm_next;
			warn_reg <= warn_next;
			mode_reg <= mode_next;
			run_reg <= run_next;
		end
	end

	// Blink timer restarts whenever blinking is not selected, so each blink opens lit
	logic [CNT_W-1:0] blink_cnt_reg;
	logic [CNT_W-1:0] blink_cnt_next;
	logic blink_ph_reg;
	logic blink_ph_next;
	logic err_led_reg;
	logic err_led_next;

	always_comb
	begin
		blink_cnt_next = blink_cnt_reg;
		blink_ph_next = blink_ph_reg;
		if (mode_reg != pms_pkg::PMS_ERR_BLINK)
		begin
			blink_cnt_next = '0;
			blink_ph_next = 1'b1;
		end
		else if (blink_cnt_reg == CNT_W'(BLINK_HALF - 1))
		begin
			blink_cnt_next = '0;
			blink_ph_next = !blink_ph_reg;
		end
		else
		begin
			blink_cnt_next = blink_cnt_reg + CNT_W'(1);
		end
		unique case (mode_reg)
			pms_pkg::PMS_ERR_OFF: err_led_next = 1'b0;
			pms_pkg::PMS_ERR_ON: err_led_next = 1'b1;
			pms_pkg::PMS_ERR_BLINK: err_led_next = blink_ph_reg;
			default: err_led_next = 1'b1;
		endcase
	end

	always_ff @(posedge ref_clk)
	begin
		if (sys_rst)
		begin
			blink_cnt_reg <= '0;
			blink_ph_reg <= 1'b1;
			err_led_reg <= 1'b0;
		end
		else
		begin
			blink_cnt_reg <= blink_cnt_next;
			blink_ph_reg <= blink_ph_next;
			err_led_reg <= err_led_next;
		end
	end

	assign rd_data = rd_data_reg;
	assign rd_valid = rd_valid_reg;
	assign lower_output_limit_bus = lo_bus_reg;
	assign upper_output_limit_bus = up_bus_reg;
	assign limit_ch = lim_ch_reg;
	assign error_code = code_reg;
	assign alarm_active = alarm_reg;
	assign warning_active = warn_reg;
	assign run_led = run_reg;
	assign err_led = err_led_reg;

endmodule : pms_status

`default_nettype wire

// ===== inc/pms_pkg.sv
// Constants and types for the channel status and fault reporting block
// Function
// - Each of the eight channels keeps its own lower output limit, zero after reset.
// - Each of the eight channels keeps its own upper output limit, zero after reset.
// - Each channel's present control output is readable, starts at zero and ignores host writes.
// - Each channel's accumulated integral term is readable, starts at zero, for all eight channels.
// - An out-of-tolerance external supply reports code a601 with RUN off and ERROR steady on.
// - A faulty cold junction compensation reports code a602 with RUN off and ERROR on.
// - Invalid factory calibration data reports code a603 with RUN off and ERROR on.
// - An alarm-class range violation reports a400 plus the channel with RUN off and ERROR on.
// - A blinking warning range violation reports a000 plus the channel, RUN on, ERROR blinking.
// - A quiet warning range violation reports a800 plus the channel, RUN on and ERROR off.
package pms_pkg;

	localparam int CHANNELS = 8;
	localparam int CH_W = 3;
	localparam int VALUE_W = 32;
	localparam int CODE_W = 16;

	localparam logic [VALUE_W-1:0] VALUE_RESET = 32'h0000_0000;
	localparam logic [CODE_W-1:0] CODE_NONE = 16'h0000;
	localparam logic [CODE_W-1:0] CODE_HW_FAIL = 16'ha600;
	localparam logic [CODE_W-1:0] CODE_SUPPLY = 16'ha601;
	localparam logic [CODE_W-1:0] CODE_CJC = 16'ha602;
	localparam logic [CODE_W-1:0] CODE_CAL = 16'ha603;
	localparam logic [CODE_W-1:0] CODE_RANGE_ALARM = 16'ha400;
	localparam logic [CODE_W-1:0] CODE_RANGE_BLINK = 16'ha000;
	localparam logic [CODE_W-1:0] CODE_RANGE_QUIET = 16'ha800;

	// Error indicator blink: half period in milliseconds, clock in kHz
	localparam int BLINK_HALF_MS = 500;
	localparam int CLK_KHZ = 125000;
	localparam int BLINK_HALF_CYCLES = BLINK_HALF_MS * CLK_KHZ;

	typedef enum logic [1:0] {
		PMS_SEL_LOWER,
		PMS_SEL_UPPER,
		PMS_SEL_OUTPUT,
		PMS_SEL_INTEGRAL
	} pms_sel_t;

	typedef enum logic [1:0] {
		PMS_ERR_OFF,
		PMS_ERR_ON,
		PMS_ERR_BLINK
	} pms_err_mode_t;

	typedef struct packed {
		logic hw_fail;
		logic supply_fault;
		logic cjc_fault;
		logic cal_fault;
		logic [CHANNELS-1:0] range_alarm;
		logic [CHANNELS-1:0] range_warn_blink;
		logic [CHANNELS-1:0] range_warn_quiet;
	} pms_faults_t;

	typedef struct packed {
		logic valid;
		logic [CH_W-1:0] ch;
		logic [VALUE_W-1:0] output_value;
		logic [VALUE_W-1:0] integral;
	} pms_loop_upd_t;

	typedef struct packed {
		logic wr_en;
		logic rd_en;
		pms_sel_t sel;
		logic [CH_W-1:0] ch;
		logic [VALUE_W-1:0] wdata;
	} pms_host_req_t;

endpackage : pms_pkg

// ===== tb/pms_status_assertions.sv
// Property checker for the status and fault reporting block
`timescale 1ns/1ns
`default_nettype none
module pms_status_checker (
	input wire logic ref_clk,
	input wire logic sys_rst,
	input wire pms_pkg::pms_host_req_t host_req,
	input wire logic rd_valid,
	input wire pms_pkg::pms_faults_t faults_async,
	input wire logic [pms_pkg::CODE_W-1:0] error_code,
	input wire logic alarm_active,
	input wire logic warning_active,
	input wire logic run_led,
	input wire logic err_led
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (sys_rst);
	// Three samples span the two-flop synchroniser and the code register
	sequence supply_only;
		(faults_async.supply_fault && !faults_async.hw_fail)[*3];
	endsequence
	sequence top_range_only;
		(faults_async[27:24] == 4'h0 && faults_async.range_alarm == 8'h80)[*3];
	endsequence
	sequence all_clear;
		(faults_async == '0)[*3];
	endsequence
	read_answer_a: assert property (host_req.rd_en |=> rd_valid)
		else $error("read strobe not answered");
	read_pulse_a: assert property (rd_valid |-> $past(host_req.rd_en))
		else $error("read valid without a read");
	supply_code_a: assert property (supply_only |=> error_code == 16'ha601 && !run_led)
		else $error("supply fault code wrong");
	range_code_a: assert property (top_range_only |=> error_code == 16'ha407 && alarm_active)
		else $error("range alarm code wrong");
	clear_code_a: assert property (all_clear |=> error_code == 16'h0000 && run_led)
		else $error("code not cleared");
	alarm_run_a: assert property (alarm_active |-> !run_led && !warning_active)
		else $error("alarm with run lit");
	alarm_err_a: assert property (alarm_active && $past(alarm_active) |-> err_led)
		else $error("alarm with error dark");
	warn_run_a: assert property (warning_active |-> run_led && error_code[15:12] == 4'ha)
		else $error("warning state wrong");
endmodule : pms_status_checker
bind pms_status pms_status_checker u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
	.host_req(host_req), .rd_valid(rd_valid), .faults_async(faults_async),
	.error_code(error_code), .alarm_active(alarm_active), .warning_active(warning_active),
	.run_led(run_led), .err_led(err_led));
`default_nettype wire

// ===== tb/pms_host_model.sv
// Host controller model issuing single-word reads and writes
`timescale 1ns/1ns
`default_nettype none
module pms_host_model (
	input wire logic ref_clk,
	output var pms_pkg::pms_host_req_t host_req,
	input wire logic [31:0] rd_data,
	input wire logic rd_valid
);
	initial host_req = '0;
	task automatic wr(input logic [1:0] sel, input logic [2:0] ch, input logic [31:0] v);
		@(posedge ref_clk);
		#1;
		host_req = {1'b1, 1'b0, sel, ch, v};
		@(posedge ref_clk);
		#1;
		// Idle data shows the inverse so a stale word cannot pass
		host_req = {1'b0, 1'b0, sel, ch, ~v};
	endtask : wr
	task automatic rd(input logic [1:0] sel, input logic [2:0] ch, output logic [31:0] v,
		output logic ok);
		@(posedge ref_clk);
		#1;
		host_req = {1'b0, 1'b1, sel, ch, host_req.wdata};
		@(posedge ref_clk);
		#1;
		host_req.rd_en = 1'b0;
		ok = rd_valid;
		v = rd_data;
	endtask : rd
endmodule : pms_host_model
`default_nettype wire

// ===== tb/tb_pms_status.sv
// Self-checking bench for the status and fault reporting block
`timescale 1ns/1ns
`default_nettype none
module tb_pms_status;
	logic ref_clk;
	logic sys_rst;
	pms_pkg::pms_host_req_t host_req;
	pms_pkg::pms_loop_upd_t loop_upd;
	pms_pkg::pms_faults_t faults_async;
	logic [31:0] rd_data;
	logic rd_valid;
	logic [15:0] error_code;
	logic alarm_active;
	logic warning_active;
	logic run_led;
	logic err_led;
	logic [31:0] lo_bus;
	logic [31:0] up_bus;
	logic [2:0] lim_ch;
	int miscompares;
	int n_tests;
	int cycles;
	// Last entry puts the top channel alarm over every warning
	localparam logic [27:0] FV [11] = '{28'h8000000, 28'h4000000, 28'h2000000, 28'h1000000,
		28'h0080000, 28'h0008000, 28'h0000001, 28'h340ffff, 28'h0600201, 28'h0000c10,
		28'h080ff01};
	localparam logic [17:0] EV [11] = '{{16'ha600, 2'b01}, {16'ha601, 2'b01}, {16'ha602, 2'b01},
		{16'ha603, 2'b01}, {16'ha403, 2'b01}, {16'ha007, 2'b11}, {16'ha800, 2'b10},
		{16'ha602, 2'b01}, {16'ha405, 2'b01}, {16'ha002, 2'b11}, {16'ha407, 2'b01}};
	pms_host_model host (.ref_clk(ref_clk), .host_req(host_req), .rd_data(rd_data),
		.rd_valid(rd_valid));
	pms_status #(.BLINK_HALF(8)) DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .host_req(host_req),
		.rd_data(rd_data), .rd_valid(rd_valid), .loop_upd(loop_upd), .faults_async(faults_async),
		.lower_output_limit_bus(lo_bus), .upper_output_limit_bus(up_bus), .limit_ch(lim_ch),
		.error_code(error_code), .alarm_active(alarm_active), .warning_active(warning_active),
		.run_led(run_led), .err_led(err_led));
	initial
	begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask : check
	task automatic summarize();
		$display("tests %0d mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask : summarize
	task automatic read_expect(input logic [1:0] sel, input logic [2:0] ch, input logic [31:0] e);
		logic [31:0] v;
		logic ok;
		host.rd(sel, ch, v, ok);
		check("read valid", {31'h0, ok}, 32'h1);
		check("read data", v, e);
	endtask : read_expect
	task automatic t_reset();
		for (int i = 0; i < 32; i++)
			read_expect(i[4:3], i[2:0], 32'h0);
		$display("reset values done");
	endtask : t_reset
	task automatic t_limits();
		for (int c = 0; c < 8; c++)
		begin
			host.wr(2'h0, c[2:0], 32'h1000_0000 + c);
			host.wr(2'h1, c[2:0], 32'h2000_0000 + c);
		end
		for (int c = 0; c < 8; c++)
		begin
			read_expect(2'h0, c[2:0], 32'h1000_0000 + c);
			read_expect(2'h1, c[2:0], 32'h2000_0000 + c);
		end
		$display("limits done");
	endtask : t_limits
	// Round robin view: after each edge the bus holds the channel shown one edge earlier
	task automatic t_limit_bus();
		logic [2:0] prev;
		@(posedge ref_clk);
		#1;
		prev = lim_ch;
		for (int k = 0; k < 8; k++)
		begin
			@(posedge ref_clk);
			#1;
			check("limit channel", {29'h0, lim_ch}, {29'h0, prev + 3'h1});
			check("lower bus", lo_bus, 32'h1000_0000 + prev);
			check("upper bus", up_bus, 32'h2000_0000 + prev);
			prev = lim_ch;
		end
		$display("limit bus done");
	endtask : t_limit_bus
	task automatic t_readonly();
		@(posedge ref_clk);
		#1;
		loop_upd = {1'b1, 3'd5, 32'h00c0_ffee, 32'h0bad_cafe};
		@(posedge ref_clk);
		#1;
		loop_upd.valid = 1'b0;
		host.wr(2'h2, 3'd5, 32'h5555_5555);
		host.wr(2'h3, 3'd5, 32'h6666_6666);
		read_expect(2'h2, 3'd5, 32'h00c0_ffee);
		read_expect(2'h3, 3'd5, 32'h0bad_cafe);
		read_expect(2'h3, 3'd4, 32'h0);
		$display("read-only values done");
	endtask : t_readonly
	task automatic t_faults();
		for (int i = 0; i < 11; i++)
		begin
			faults_async = FV[i];
			repeat (6) @(posedge ref_clk);
			#1;
			check("code", {16'h0, error_code}, {16'h0, EV[i][17:2]});
			check("leds", {30'h0, run_led, err_led}, {30'h0, EV[i][1:0]});
			check("alarm", {31'h0, alarm_active}, {31'h0, ~EV[i][1]});
			check("warning", {31'h0, warning_active}, {31'h0, EV[i][1]});
			if (i == 5)
			begin
				repeat (8) @(posedge ref_clk);
				#1;
				check("blink", {31'h0, err_led}, 32'h0);
			end
			faults_async = '0;
			repeat (6) @(posedge ref_clk);
			#1;
			check("clear", {15'h0, run_led, error_code}, 32'h0001_0000);
			check("clear flags", {29'h0, alarm_active, warning_active, err_led}, 32'h0);
		end
		$display("fault codes done");
	endtask : t_faults
	always @(posedge ref_clk)
	begin
		cycles++;
		if (cycles == 3000)
		begin
			miscompares++;
			summarize();
		end
	end
	initial
	begin
		miscompares = 0;
		n_tests = 0;
		cycles = 0;
		sys_rst = 1'b1;
		loop_upd = '0;
		faults_async = '0;
		repeat (10) @(posedge ref_clk);
		#1;
		sys_rst = 1'b0;
		t_reset();
		t_limits();
		t_limit_bus();
		t_readonly();
		t_faults();
		summarize();
	end
endmodule : tb_pms_status
`default_nettype wire
